// file: core/oiip_filter.sv
// Level filter for one sensor input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module oiip_filter #(
  parameter int LONG_CYC = oiip_pkg::FILT_CYC,
  parameter int SHORT_CYC = oiip_pkg::MIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic filt_en,
  // Level
  input wire logic raw,
  output logic level_q
);

  localparam int CW = $clog2(LONG_CYC + 1);
  localparam logic [CW-1:0] LONG_M1 = CW'(LONG_CYC - 1);
  localparam logic [CW-1:0] SHORT_M1 = CW'(SHORT_CYC - 1);

  // A one-cycle window would let single-cycle glitches through
  if (SHORT_CYC < 2 || LONG_CYC < SHORT_CYC) begin : g_bad_len
    $error("oiip_filter: bad filter lengths");
  end


  logic [CW-1:0] cnt_q;
  logic [CW-1:0] limit;

  assign limit = filt_en ? LONG_M1 : SHORT_M1;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else if (raw == level_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= limit) begin
      cnt_q <= '0;
      level_q <= raw;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  property p_filt_change;
    @(posedge clk) disable iff (reset)
      $changed(level_q) |-> $past(raw) == level_q;
  endproperty
  a_filt_change: assert property (p_filt_change)
    else $error("filter took a level the input did not hold");

  property p_filt_two;
    @(posedge clk) disable iff (reset)
      ($changed(level_q) && !$past(filt_en)) |-> $past(raw, 2) == level_q;
  endproperty
  a_filt_two: assert property (p_filt_two)
    else $error("filter passed a one-cycle pulse");

  property p_filt_long;
    @(posedge clk) disable iff (reset)
      ($changed(level_q) && $past(filt_en, 1) && $past(filt_en, 8))
        |-> $past(raw, 8) == level_q;
  endproperty
  a_filt_long: assert property (p_filt_long)
    else $error("filter passed a short pulse");

endmodule : oiip_filter
`default_nettype wire

// file: core/oiip_index_count.sv
// Counter of active index edges toward a programmed target.
// Assumes a filtered, synchronous index level.
`timescale 1ns/100ps
`default_nettype none
module oiip_index_count #(
  parameter int CNT_W = oiip_pkg::EZCNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic enable,
  input wire logic rise_sel,
  input wire logic [CNT_W-1:0] target,
  // Index level
  input wire logic level,
  // Result
  output logic reached_q
);

  // A counter needs at least one bit
  if (CNT_W < 1) begin : g_bad_width
    $error("oiip_index_count: bad width");
  end


  logic prev_q;
  logic done_q;
  logic [CNT_W-1:0] cnt_q;
  logic edge_hit;

  assign edge_hit = rise_sel ? (level && !prev_q) : (!level && prev_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || clear) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      reached_q <= 1'b0;
    end else begin
      reached_q <= 1'b0;
      if (enable && edge_hit && !done_q) begin
        cnt_q <= cnt_q + CNT_W'(1);
        if (cnt_q == target) begin
          done_q <= 1'b1;
          reached_q <= 1'b1;
        end
      end
    end
  end

  property p_reach;
    @(posedge clk) disable iff (reset)
      reached_q |-> $past(edge_hit) && $past(cnt_q) == $past(target);
  endproperty
  a_reach: assert property (p_reach)
    else $error("index target reached at wrong count");

endmodule : oiip_index_count
`default_nettype wire

// file: core/oiip_pkg.sv
// Constants, types and register map for the origin, index and
// in-position input block of one axis.
// Assumes a 10 MHz reference clock and a plain strobe register port.
package oiip_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 100;
  localparam int FILT_NS = 4000;
  // Pulses up to and including the filter time are rejected
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int MIN_CYC = 2;

  // ****************************************
  // Register map
  // ****************************************
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_MODE = 8'h00;
  localparam logic [AW-1:0] ADDR_ENV1 = 8'h04;
  localparam logic [AW-1:0] ADDR_ENV2 = 8'h08;
  localparam logic [AW-1:0] ADDR_ENV3 = 8'h0C;
  localparam logic [AW-1:0] ADDR_SUB = 8'h10;
  localparam logic [AW-1:0] ADDR_EXT = 8'h14;
  localparam logic [AW-1:0] ADDR_MAIN = 8'h18;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_W = 7;
  localparam int MODE_DIR_BIT = 3;
  localparam int WAIT_BIT = 9;
  localparam int ORG_POL_BIT = 7;
  localparam int INP_POL_BIT = 22;
  localparam int FILT_BIT = 26;
  localparam int EZ_EDGE_BIT = 23;
  localparam int EZCNT_LSB = 4;
  localparam int EZCNT_W = 4;
  localparam int SUB_ORG_BIT = 14;
  localparam int EXT_EZ_BIT = 10;
  localparam int EXT_INP_BIT = 16;
  localparam int STOP_W = 6;
  localparam int OPST_W = 4;

  // ****************************************
  // Mode codes, positive direction, and the direction bit mask
  // ****************************************
  localparam logic [MODE_W-1:0] MODE_ZERO_RET = 7'h10;
  localparam logic [MODE_W-1:0] MODE_LEAVE_ZERO = 7'h12;
  localparam logic [MODE_W-1:0] MODE_ZERO_SEARCH = 7'h15;
  localparam logic [MODE_W-1:0] MODE_INDEX_CNT = 7'h24;
  localparam logic [MODE_W-1:0] MODE_DIR_MASK = 7'h08;

  // ****************************************
  // Operation state codes
  // ****************************************
  localparam logic [OPST_W-1:0] OPST_IDLE = 4'h0;
  localparam logic [OPST_W-1:0] OPST_RUN = 4'h1;
  localparam logic [OPST_W-1:0] OPST_WAIT = 4'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_WAIT = 3'h4
  } oiip_state_t;

  typedef struct packed {
    logic mode_on;
    logic org_high;
    logic inp_high;
    logic ez_rise;
    logic filt_env1;
    logic filt_env2;
    logic wait_inp;
    logic [EZCNT_W-1:0] ez_target;
  } oiip_cfg_t;

endpackage : oiip_pkg

// file: core/oiip_top.sv
// Origin, index and in-position input handling for one axis.
// Assumes synchronous sensor pins, a motion core that reports start and
// end of pulse output, and a single-cycle strobe register port.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module oiip_top #(
  parameter int FILT_CYC = oiip_pkg::FILT_CYC,
  parameter int MIN_CYC = oiip_pkg::MIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [oiip_pkg::AW-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data_q,
  // Sensor pins
  input wire logic origin_sensor_in,
  input wire logic encoder_index_in,
  input wire logic in_position_in,
  // Motion core
  input wire logic op_start,
  input wire logic pulse_done,
  input wire logic [oiip_pkg::STOP_W-1:0] stop_cause,
  // Results
  output logic busy_out_n,
  output logic op_done_q,
  output logic origin_latched_q,
  output logic index_reached_q
);

  // A short window under two cycles, or a long window shorter than the short one, is refused while building the block
  if (MIN_CYC < 2 || FILT_CYC < MIN_CYC) begin : g_bad_len
    $error("oiip_top: bad filter lengths");
  end


  // ****************************************
  // Configuration registers
  // ****************************************
  logic [31:0] mode_q;
  logic [31:0] env1_q;
  logic [31:0] env2_q;
  logic [31:0] env3_q;
  oiip_pkg::oiip_cfg_t cfg;
  logic [oiip_pkg::MODE_W-1:0] mode_pos;

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= oiip_pkg::REG_RESET;
      env1_q <= oiip_pkg::REG_RESET;
      env2_q <= oiip_pkg::REG_RESET;
      env3_q <= oiip_pkg::REG_RESET;
    end else if (wr_en) begin
      if (addr == oiip_pkg::ADDR_MODE) begin
        mode_q <= wr_data;
      end else if (addr == oiip_pkg::ADDR_ENV1) begin
        env1_q <= wr_data;
      end else if (addr == oiip_pkg::ADDR_ENV2) begin
        env2_q <= wr_data;
      end else if (addr == oiip_pkg::ADDR_ENV3) begin
        env3_q <= wr_data;
      end
    end
  end

  assign mode_pos = mode_q[oiip_pkg::MODE_W-1:0] & ~oiip_pkg::MODE_DIR_MASK;

  assign cfg.mode_on = (mode_pos == oiip_pkg::MODE_ZERO_RET) ||
                       (mode_pos == oiip_pkg::MODE_LEAVE_ZERO) ||
                       (mode_pos == oiip_pkg::MODE_ZERO_SEARCH) ||
                       (mode_pos == oiip_pkg::MODE_INDEX_CNT);
  assign cfg.org_high = env1_q[oiip_pkg::ORG_POL_BIT];
  assign cfg.inp_high = env1_q[oiip_pkg::INP_POL_BIT];
  assign cfg.ez_rise = env2_q[oiip_pkg::EZ_EDGE_BIT];
  assign cfg.filt_env1 = env1_q[oiip_pkg::FILT_BIT];
  assign cfg.filt_env2 = env2_q[oiip_pkg::FILT_BIT];
  assign cfg.wait_inp = mode_q[oiip_pkg::WAIT_BIT];
  assign cfg.ez_target = env3_q[oiip_pkg::EZCNT_LSB +: oiip_pkg::EZCNT_W];

  // ****************************************
  // Input polarity and filters
  // ****************************************
  logic org_raw;
  logic inp_raw;
  logic org_act;
  logic inp_act;
  logic ez_lvl;
  logic ez_act;

  // Origin and in-position polarity is applied before filtering; the index filter sees the raw pin
  assign org_raw = cfg.org_high ? origin_sensor_in : !origin_sensor_in;
  assign inp_raw = cfg.inp_high ? in_position_in : !in_position_in;

  oiip_filter #(
    .LONG_CYC(FILT_CYC),
    .SHORT_CYC(MIN_CYC)
  ) u_org_filt (
    .clk(clk),
    .reset(reset),
    .filt_en(cfg.filt_env1),
    .raw(org_raw),
    .level_q(org_act)
  );

  oiip_filter #(
    .LONG_CYC(FILT_CYC),
    .SHORT_CYC(MIN_CYC)
  ) u_inp_filt (
    .clk(clk),
    .reset(reset),
    .filt_en(cfg.filt_env1),
    .raw(inp_raw),
    .level_q(inp_act)
  );

  oiip_filter #(
    .LONG_CYC(FILT_CYC),
    .SHORT_CYC(MIN_CYC)
  ) u_ez_filt (
    .clk(clk),
    .reset(reset),
    .filt_en(cfg.filt_env2),
    .raw(encoder_index_in),
    .level_q(ez_lvl)
  );

  assign ez_act = cfg.ez_rise ? ez_lvl : !ez_lvl;

  // ****************************************
  // Origin latch and index count
  // ****************************************
  logic run_clear;

  assign run_clear = op_start || pulse_done;

  always_ff @(posedge clk) begin
    if (reset) begin
      origin_latched_q <= 1'b0;
    end else if (cfg.mode_on && org_act) begin
      origin_latched_q <= 1'b1;
    end else if (pulse_done) begin
      origin_latched_q <= 1'b0;
    end
  end

  oiip_index_count #(
    .CNT_W(oiip_pkg::EZCNT_W)
  ) u_index (
    .clk(clk),
    .reset(reset),
    .clear(run_clear),
    .enable(cfg.mode_on),
    .rise_sel(cfg.ez_rise),
    .target(cfg.ez_target),
    .level(ez_lvl),
    .reached_q(index_reached_q)
  );

  // ****************************************
  // Completion gating
  // ****************************************
  oiip_pkg::oiip_state_t st_q;
  logic [oiip_pkg::STOP_W-1:0] cause_q;
  logic [oiip_pkg::STOP_W-1:0] stop_bits_q;
  logic [oiip_pkg::OPST_W-1:0] opst_q;
  logic finish;

  // no delay when already in position
  assign finish = ((st_q == oiip_pkg::ST_RUN) && pulse_done &&
                   (!cfg.wait_inp || inp_act)) ||
                  ((st_q == oiip_pkg::ST_WAIT) && inp_act);

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= oiip_pkg::ST_IDLE;
    end else begin
      case (st_q)
        oiip_pkg::ST_IDLE: begin
          if (op_start) begin
            st_q <= oiip_pkg::ST_RUN;
          end
        end
        oiip_pkg::ST_RUN: begin
          if (finish) begin
            st_q <= oiip_pkg::ST_IDLE;
          end else if (pulse_done) begin
            st_q <= oiip_pkg::ST_WAIT;
          end
        end
        oiip_pkg::ST_WAIT: begin
          if (finish) begin
            st_q <= oiip_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= oiip_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cause_q <= '0;
    end else if (pulse_done && (st_q == oiip_pkg::ST_RUN)) begin
      cause_q <= stop_cause;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_out_n <= 1'b1;
      op_done_q <= 1'b0;
      stop_bits_q <= '0;
      opst_q <= oiip_pkg::OPST_IDLE;
    end else begin
      op_done_q <= finish;
      if (finish) begin
        busy_out_n <= 1'b1;
        opst_q <= oiip_pkg::OPST_IDLE;
        stop_bits_q <= (st_q == oiip_pkg::ST_RUN) ? stop_cause : cause_q;
      end else if ((st_q == oiip_pkg::ST_IDLE) && op_start) begin
        busy_out_n <= 1'b0;
        opst_q <= oiip_pkg::OPST_RUN;
      end else if ((st_q == oiip_pkg::ST_RUN) && pulse_done) begin
        opst_q <= oiip_pkg::OPST_WAIT;
      end
    end
  end

  // ****************************************
  // Status read
  // ****************************************
  logic [31:0] sub_word;
  logic [31:0] ext_word;
  logic [31:0] main_word;

  always_comb begin
    sub_word = 32'h0000_0000;
    sub_word[oiip_pkg::SUB_ORG_BIT] = org_act;
  end

  always_comb begin
    ext_word = 32'h0000_0000;
    ext_word[oiip_pkg::OPST_W-1:0] = opst_q;
    ext_word[oiip_pkg::EXT_EZ_BIT] = ez_act;
    ext_word[oiip_pkg::EXT_INP_BIT] = inp_act;
  end

  always_comb begin
    main_word = 32'h0000_0000;
    main_word[oiip_pkg::STOP_W-1:0] = stop_bits_q;
  end

  // Unmapped addresses read as zero, never stall
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_q <= 32'h0000_0000;
    end else if (!rd_en) begin
      rd_data_q <= 32'h0000_0000;
    end else if (addr == oiip_pkg::ADDR_MODE) begin
      rd_data_q <= mode_q;
    end else if (addr == oiip_pkg::ADDR_ENV1) begin
      rd_data_q <= env1_q;
    end else if (addr == oiip_pkg::ADDR_ENV2) begin
      rd_data_q <= env2_q;
    end else if (addr == oiip_pkg::ADDR_ENV3) begin
      rd_data_q <= env3_q;
    end else if (addr == oiip_pkg::ADDR_SUB) begin
      rd_data_q <= sub_word;
    end else if (addr == oiip_pkg::ADDR_EXT) begin
      rd_data_q <= ext_word;
    end else if (addr == oiip_pkg::ADDR_MAIN) begin
      rd_data_q <= main_word;
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_ext_read;
    rd_en && addr == oiip_pkg::ADDR_EXT;
  endsequence

  sequence s_run_end;
    st_q == oiip_pkg::ST_RUN && pulse_done;
  endsequence

  property p_mode_gate;
    @(posedge clk) disable iff (reset)
      (!cfg.mode_on && !origin_latched_q) |=> !origin_latched_q;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("origin latched outside homing modes");

  property p_latch_hold;
    @(posedge clk) disable iff (reset)
      (origin_latched_q && !pulse_done) |=> origin_latched_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("origin latch dropped while moving");

  property p_latch_clear;
    @(posedge clk) disable iff (reset)
      (pulse_done && !(cfg.mode_on && org_act)) |=> !origin_latched_q;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("origin latch kept after stop");

  property p_mode_neg;
    @(posedge clk) disable iff (reset)
      (mode_q[oiip_pkg::MODE_W-1:0] == (oiip_pkg::MODE_ZERO_RET |
        oiip_pkg::MODE_DIR_MASK)) |-> cfg.mode_on;
  endproperty
  a_mode_neg: assert property (p_mode_neg)
    else $error("negative zero return not decoded");

  property p_sub_read;
    @(posedge clk) disable iff (reset)
      (rd_en && addr == oiip_pkg::ADDR_SUB)
        |=> rd_data_q[oiip_pkg::SUB_ORG_BIT] == $past(org_act);
  endproperty
  a_sub_read: assert property (p_sub_read)
    else $error("origin state misreported");

  property p_ext_read;
    @(posedge clk) disable iff (reset)
      s_ext_read |=> rd_data_q[oiip_pkg::EXT_EZ_BIT] == $past(ez_act) &&
        rd_data_q[oiip_pkg::EXT_INP_BIT] == $past(inp_act);
  endproperty
  a_ext_read: assert property (p_ext_read)
    else $error("extension status misreported");

  property p_busy_rise;
    @(posedge clk) disable iff (reset)
      $rose(busy_out_n) |-> op_done_q;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy released without completion");

  property p_at_once;
    @(posedge clk) disable iff (reset)
      (s_run_end and inp_act) |=> busy_out_n && op_done_q;
  endproperty
  a_at_once: assert property (p_at_once)
    else $error("in-position completion delayed");

  property p_wait_inp;
    @(posedge clk) disable iff (reset)
      (s_run_end and (cfg.wait_inp && !inp_act))
        |=> !busy_out_n && st_q == oiip_pkg::ST_WAIT;
  endproperty
  a_wait_inp: assert property (p_wait_inp)
    else $error("completion did not wait for in-position");

endmodule : oiip_top
`default_nettype wire

// file: verification/oiip_partner.sv
// Model of the origin sensor, index encoder and servo driver pins.
// Assumes the bench calls its tasks from one process, off or on clk edges.
`timescale 1ns/100ps
`default_nettype none
module oiip_partner (
  // Clock
  input wire logic clk,
  // Pin sense per input, 1 = active high: [0] origin, [1] index, [2] in-position
  input wire logic [2:0] pol_high,
  // Pins
  output logic origin_sensor_in,
  output logic encoder_index_in,
  output logic in_position_in
);
  logic [2:0] act_q = 3'h0;

  // Sensors always drive their pins, so no released level here
  assign origin_sensor_in = act_q[0] ~^ pol_high[0];
  assign encoder_index_in = act_q[1] ~^ pol_high[1];
  assign in_position_in = act_q[2] ~^ pol_high[2];

  task automatic set(input logic [2:0] a);
    act_q <= a;
  endtask : set

  // pulse width
  // Widths under the minimum are only used where a pulse must be refused
  task automatic pulse(input int sel, input int width);
    act_q[sel] <= 1'b1;
    repeat (width) @(posedge clk);
    act_q[sel] <= 1'b0;
  endtask : pulse
endmodule : oiip_partner
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the origin, index and in-position block.
// Assumes the partner model drives the sensor pins; filter shortened to 8.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int FC = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [oiip_pkg::AW-1:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic op_start = 1'b0;
  logic pulse_done = 1'b0;
  logic [5:0] stop_cause = 6'h00;
  logic [2:0] pol_q = 3'h7;
  logic [7:0] lfsr_q = 8'h2C;
  logic [6:0] codes [4] = '{7'h10, 7'h12, 7'h15, 7'h24};
  logic [31:0] m [4];
  logic [31:0] rd_data_q;
  logic busy_out_n;
  logic op_done_q;
  logic origin_latched_q;
  logic index_reached_q;
  logic origin_sensor_in;
  logic encoder_index_in;
  logic in_position_in;
  int err_total = 0;
  int compares = 0;
  int done_n = 0;
  int reach_n = 0;
  int t;
  int r;
  int d;
  logic [31:0] v;
  logic [5:0] c;

  initial forever #50 clk = ~clk;

  oiip_top #(.FILT_CYC(FC), .MIN_CYC(2)) DUT (
    .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data_q(rd_data_q), .origin_sensor_in(origin_sensor_in),
    .encoder_index_in(encoder_index_in), .in_position_in(in_position_in),
    .op_start(op_start), .pulse_done(pulse_done), .stop_cause(stop_cause),
    .busy_out_n(busy_out_n), .op_done_q(op_done_q),
    .origin_latched_q(origin_latched_q), .index_reached_q(index_reached_q));

  oiip_partner PART (
    .clk(clk), .pol_high(pol_q), .origin_sensor_in(origin_sensor_in),
    .encoder_index_in(encoder_index_in), .in_position_in(in_position_in));

  // One-cycle events are counted here, so no check can miss them
  always @(posedge clk) begin
    if (op_done_q === 1'b1) done_n++;
    if (index_reached_q === 1'b1) reach_n++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [7:0] nxt();
    lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    return lfsr_q;
  endfunction : nxt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  task automatic print_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    if (a < 8'h10) m[a[3:2]] = dt;
    @(posedge clk);
    addr <= a;
    wr_data <= dt;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data_q, exp);
  endtask : rd

  task automatic strobe();
    @(posedge clk);
    op_start <= 1'b1;
    @(posedge clk);
    op_start <= 1'b0;
  endtask : strobe

  task automatic pdone(input logic [5:0] cs);
    @(posedge clk);
    pulse_done <= 1'b1;
    stop_cause <= cs;
    @(posedge clk);
    pulse_done <= 1'b0;
  endtask : pdone

  task automatic wait_done(input int lim);
    int i;
    i = 0;
    while (busy_out_n !== 1'b1 && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (busy_out_n !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_done

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4), 32'h0000_0000);
      v = {4{nxt()}};
      wr(8'(i * 4), v);
      rd(8'(i * 4), m[i]);
    end
    wr(oiip_pkg::ADDR_ENV1, 32'h0040_0080);
    wr(oiip_pkg::ADDR_ENV2, 32'h0080_0000);
    wr(oiip_pkg::ADDR_ENV3, 32'h0000_0000);
    wr(oiip_pkg::ADDR_MODE, 32'h0000_0000);
    pdone(6'h00);
    wr(oiip_pkg::ADDR_SUB, 32'hFFFF_FFFF);
    rd(oiip_pkg::ADDR_SUB, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    rd(oiip_pkg::ADDR_MAIN, 32'h0000_0000);
    PART.set(3'h7);
    repeat (4) @(posedge clk);
    rd(oiip_pkg::ADDR_SUB, 32'h0000_4000);
    rd(oiip_pkg::ADDR_EXT, 32'h0001_0400);
    chk(32'(origin_latched_q), 32'h0000_0000);
    wr(oiip_pkg::ADDR_ENV1, 32'h0000_0000);
    wr(oiip_pkg::ADDR_ENV2, 32'h0000_0000);
    repeat (4) @(posedge clk);
    rd(oiip_pkg::ADDR_SUB, 32'h0000_0000);
    rd(oiip_pkg::ADDR_EXT, 32'h0000_0000);
    wr(oiip_pkg::ADDR_ENV1, 32'h0040_0080);
    wr(oiip_pkg::ADDR_ENV2, 32'h0080_0000);
    PART.set(3'h0);
    // Every homing and count code in both directions, then one code outside
    for (int i = 0; i < 9; i++) begin
      v = 32'(codes[i % 4]);
      if (i > 3) v[3] = 1'b1;
      if (i == 8) v = 32'h0000_0011;
      wr(oiip_pkg::ADDR_MODE, v);
      PART.pulse(0, 2);
      repeat (4) @(posedge clk);
      chk(32'(origin_latched_q), 32'(i < 8));
      pdone(6'h00);
      #1 chk(32'(origin_latched_q), 32'h0000_0000);
    end
    // Rising, falling, then rising with the filter on
    for (int p = 0; p < 3; p++) begin
      pol_q <= {1'b1, p != 1, 1'b1};
      wr(oiip_pkg::ADDR_ENV2, {5'h00, p == 2, 2'h0, p != 1, 23'h00_0000});
      t = nxt() % 4;
      wr(oiip_pkg::ADDR_ENV3, 32'(t) << 4);
      wr(oiip_pkg::ADDR_MODE, 32'h0000_0024);
      strobe();
      r = reach_n;
      for (int k = 0; k <= t; k++) begin
        PART.pulse(1, p == 2 ? FC - 1 : 1);
        repeat (FC + 2) @(posedge clk);
        chk_n(reach_n, r);
        PART.pulse(1, p == 2 ? FC + 1 : 2);
        repeat (FC + 2) @(posedge clk);
      end
      chk_n(reach_n, r + 1);
      pdone(6'h00);
    end
    wr(oiip_pkg::ADDR_ENV1, 32'h0440_0080);
    wr(oiip_pkg::ADDR_MODE, 32'h0000_0210);
    d = done_n;
    strobe();
    #1 chk(32'(busy_out_n), 32'h0000_0000);
    rd(oiip_pkg::ADDR_EXT, 32'h0000_0001);
    v = {4{nxt()}};
    c = v[5:0];
    pdone(c);
    #1 chk(32'(busy_out_n), 32'h0000_0000);
    rd(oiip_pkg::ADDR_EXT, 32'h0000_0002);
    rd(oiip_pkg::ADDR_MAIN, 32'h0000_0000);
    PART.pulse(2, FC - 1);
    repeat (FC + 2) @(posedge clk);
    chk(32'(busy_out_n), 32'h0000_0000);
    PART.set(3'h4);
    wait_done(FC + 4);
    @(posedge clk);
    #1 chk_n(done_n, d + 1);
    rd(oiip_pkg::ADDR_MAIN, {26'h000_0000, c});
    rd(oiip_pkg::ADDR_EXT, 32'h0001_0000);
    strobe();
    v = {4{nxt()}};
    c = v[5:0];
    pdone(c);
    #1 chk(32'(busy_out_n), 32'h0000_0001);
    rd(oiip_pkg::ADDR_MAIN, {26'h000_0000, c});
    PART.set(3'h0);
    wr(oiip_pkg::ADDR_MODE, 32'h0000_0010);
    repeat (FC + 2) @(posedge clk);
    strobe();
    pdone(6'h15);
    #1 chk(32'(busy_out_n), 32'h0000_0001);
    @(posedge clk);
    #1 chk_n(done_n, d + 3);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
